/* hw/crs_exec_core.sv */
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module crs_exec_core (
  input wire logic sys_clk, // Core clock, one quarter phase per edge
  input wire logic rst, // Synchronous reset, active high
  input wire logic masterClearPin_n, // External master clear pin, low
  input wire logic [15:0] opcode, // Instruction word from fetch
  input wire logic [20:0] instrAddr, // Address of that instruction
  input wire logic opValid, // Opcode valid, sampled in Q1
  input wire logic lowPrioReturn, // Interrupt return is from low level
  input wire logic intEnableClr, // Interrupt entry clears enables
  input wire logic [7:0] workingShadow, // Shadow of W
  input wire logic [7:0] statusShadow, // Shadow of status
  input wire logic [3:0] bankSelectShadow, // Shadow of bank select
  input wire logic latchWe, // Write both PC latches
  input wire logic [12:0] latchData, // {upper[4:0], high[7:0]}
  input wire logic [1:0] regAddr, // Register port address
  input wire logic [31:0] regWrData, // Register write data
  input wire logic regWrStb, // Register write strobe
  input wire logic regRdStb, // Register read strobe
  output logic [31:0] regRdData, // Read data, cycle after strobe
  output logic [20:0] pcOut, // Program counter
  output logic pcLoad, // Pulse: PC loaded by call or return
  output logic [7:0] workingReg, // Working register
  output logic [7:0] statusReg, // Status register
  output logic [3:0] bankSelectReg, // Bank select register
  output logic highPrioIntEnable, // High priority global enable
  output logic lowPrioIntEnable, // Low priority global enable
  output logic [4:0] pcUpperLatch, // PC upper latch
  output logic [7:0] pcHighLatch, // PC high latch
  output logic [20:0] stackTop, // Top of return stack, one cycle late
  output logic [1:0] qPhase, // Current quarter phase
  output logic idleCycle, // Second, idle cycle of a two-cycle op
  output logic softReset // Pulse: reset instruction fires
);
  crs_stack_if stk ();

  logic clrMeta_r;
  logic clrSync_r;
  logic effRst;
  logic [1:0] qPhase_r;
  crs_pkg::crs_op_type op_r;
  crs_pkg::crs_op_type opDec;
  logic [15:0] opcode_r;
  logic [20:0] instrAddr_r;
  logic [20:0] retAddr;
  logic [20:0] callTarget;
  logic twoCycle;
  logic isQ2;
  logic isQ4;
  logic ctrlEn_r;
  logic idleCycle_r;
  logic softReset_r;
  logic pcLoad_r;
  logic [20:0] pc_r;
  logic [7:0] working_r;
  logic [7:0] status_r;
  logic [3:0] bankSel_r;
  logic highIe_r;
  logic lowIe_r;
  logic [4:0] pcUpper_r;
  logic [7:0] pcHigh_r;
  logic [20:0] stackTop_r;
  logic [31:0] rdData_r;
  logic shadowSel;

  crs_return_stack u_stack (
    .sys_clk(sys_clk),
    .rst(effRst),
    .stk(stk)
  );

  // Master clear pin is asynchronous, two flops before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clrMeta_r <= 1'b1;
      clrSync_r <= 1'b1;
    end else begin
      clrMeta_r <= masterClearPin_n;
      clrSync_r <= clrMeta_r;
    end
  end

  // Reset instruction and pin both act as a master clear of all but the control, read-data, pin synchronizer and stack entry registers
  assign effRst = rst || !clrSync_r || softReset_r;

  // Opcode decode of the handled subset
  always_comb begin
    opDec = crs_pkg::OP_OTHER;
    if (opcode[15:11] == crs_pkg::CALL_PFX) begin
      opDec = crs_pkg::OP_CALL;
    end else if (opcode == crs_pkg::RESET_OPC) begin
      opDec = crs_pkg::OP_RESET;
    end else if (opcode[15:1] == crs_pkg::INTRET_PFX) begin
      opDec = crs_pkg::OP_INTRET;
    end else if (opcode[15:8] == crs_pkg::LITRET_PFX) begin
      opDec = crs_pkg::OP_LITRET;
    end else if (opcode == crs_pkg::PUSH_OPC) begin
      opDec = crs_pkg::OP_PUSH;
    end
  end

  // Return address and sign-extended word offset target
  assign retAddr = instrAddr_r + crs_pkg::RET_OFFSET;
  assign callTarget = retAddr + {{9{opcode_r[crs_pkg::OFS_MSB]}},
                      opcode_r[crs_pkg::OFS_MSB:0], 1'b0};
  assign twoCycle = (op_r == crs_pkg::OP_CALL) ||
                    (op_r == crs_pkg::OP_INTRET) ||
                    (op_r == crs_pkg::OP_LITRET);
  assign isQ2 = (qPhase_r == crs_pkg::Q_2);
  assign isQ4 = (qPhase_r == crs_pkg::Q_4);
  assign shadowSel = (op_r == crs_pkg::OP_INTRET) && opcode_r[0];

  // Quarter phase counter, restarts at Q1 after any reset
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      qPhase_r <= crs_pkg::Q_1;
    end else begin
      qPhase_r <= qPhase_r + 2'h1;
    end
  end

  // Capture the instruction in Q1; idle cycles load OP_NONE into op_r
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      op_r <= crs_pkg::OP_NONE;
      opcode_r <= 16'h0000;
      instrAddr_r <= crs_pkg::PC_RST;
    end else if (qPhase_r == crs_pkg::Q_1) begin
      opcode_r <= opcode;
      instrAddr_r <= instrAddr;
      if (!idleCycle_r && opValid && ctrlEn_r) begin
        op_r <= opDec;
      end else begin
        op_r <= crs_pkg::OP_NONE;
      end
    end
  end

  // Second cycle of calls and returns is idle while fetch refills
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      idleCycle_r <= 1'b0;
    end else if (isQ4) begin
      idleCycle_r <= twoCycle;
    end
  end

  // Stack traffic: pushes in Q2, pops in Q4
  always_comb begin
    stk.push = isQ2 && ((op_r == crs_pkg::OP_CALL) ||
                        (op_r == crs_pkg::OP_PUSH));
    stk.pushData = retAddr;
    stk.pop = isQ4 && ((op_r == crs_pkg::OP_INTRET) ||
                       (op_r == crs_pkg::OP_LITRET));
    stk.clear = 1'b0;
  end

  // Reset instruction fires in Q2; the clear lands on the next edge
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      softReset_r <= 1'b0;
    end else begin
      softReset_r <= isQ2 && (op_r == crs_pkg::OP_RESET);
    end
  end

  // Program counter, written only in Q4
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      pc_r <= crs_pkg::PC_RST;
      pcLoad_r <= 1'b0;
    end else begin
      pcLoad_r <= 1'b0;
      if (isQ4) begin
        case (op_r)
          crs_pkg::OP_CALL: begin
            pc_r <= callTarget;
            pcLoad_r <= 1'b1;
          end
          crs_pkg::OP_INTRET, crs_pkg::OP_LITRET: begin
            pc_r <= stk.top;
            pcLoad_r <= 1'b1;
          end
          crs_pkg::OP_PUSH, crs_pkg::OP_OTHER: begin
            pc_r <= retAddr;
          end
          default: begin
            pc_r <= pc_r;
          end
        endcase
      end
    end
  end

  // Working register: literal return or shadow restore in Q4
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      working_r <= crs_pkg::W_RST;
    end else if (isQ4 && op_r == crs_pkg::OP_LITRET) begin
      working_r <= opcode_r[7:0];
    end else if (isQ4 && shadowSel) begin
      working_r <= workingShadow;
    end
  end

  // Status and bank select follow the shadows only when s is set
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      status_r <= crs_pkg::STATUS_RST;
      bankSel_r <= crs_pkg::BANK_RST;
    end else if (isQ4 && shadowSel) begin
      status_r <= statusShadow;
      bankSel_r <= bankSelectShadow;
    end
  end

  // Global enables: interrupt return sets the selected one, interrupt entry clears, set wins
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      highIe_r <= 1'b0;
      lowIe_r <= 1'b0;
    end else if (isQ4 && op_r == crs_pkg::OP_INTRET) begin
      if (lowPrioReturn) begin
        lowIe_r <= 1'b1;
        highIe_r <= highIe_r && !intEnableClr;
      end else begin
        highIe_r <= 1'b1;
        lowIe_r <= lowIe_r && !intEnableClr;
      end
    end else if (intEnableClr) begin
      highIe_r <= 1'b0;
      lowIe_r <= 1'b0;
    end
  end

  // PC latches change only by their own write or a reset, never by a return
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      pcUpper_r <= crs_pkg::PCU_RST;
      pcHigh_r <= crs_pkg::PCH_RST;
    end else if (latchWe) begin
      pcUpper_r <= latchData[12:8];
      pcHigh_r <= latchData[7:0];
    end
  end

  // Registered copy of the top entry for the output pin
  always_ff @(posedge sys_clk) begin
    if (effRst) begin
      stackTop_r <= crs_pkg::PC_RST;
    end else begin
      stackTop_r <= stk.top;
    end
  end

  // Control register; of the resets only the plain one touches it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrlEn_r <= crs_pkg::CTRL_EN_RST;
    end else if (regWrStb && regAddr == crs_pkg::ADDR_CTRL) begin
      ctrlEn_r <= regWrData[crs_pkg::CTRL_EN_BIT];
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_r <= 32'h00000000;
    end else if (regRdStb) begin
      rdData_r <= 32'h00000000;
      case (regAddr)
        crs_pkg::ADDR_CTRL: rdData_r[crs_pkg::CTRL_EN_BIT] <= ctrlEn_r;
        crs_pkg::ADDR_STATE: begin
          rdData_r[crs_pkg::PTR_W-1:0] <= stk.depth;
          rdData_r[crs_pkg::ST_IDLE_BIT] <= idleCycle_r;
          rdData_r[crs_pkg::ST_HIE_BIT] <= highIe_r;
          rdData_r[crs_pkg::ST_LIE_BIT] <= lowIe_r;
        end
        crs_pkg::ADDR_PC: rdData_r[crs_pkg::PC_W-1:0] <= pc_r;
        crs_pkg::ADDR_TOP: rdData_r[crs_pkg::PC_W-1:0] <= stk.top;
        default: rdData_r <= 32'h00000000;
      endcase
    end else begin
      rdData_r <= 32'h00000000;
    end
  end

  // Outputs straight from flops
  assign regRdData = rdData_r;
  assign pcOut = pc_r;
  assign pcLoad = pcLoad_r;
  assign workingReg = working_r;
  assign statusReg = status_r;
  assign bankSelectReg = bankSel_r;
  assign highPrioIntEnable = highIe_r;
  assign lowPrioIntEnable = lowIe_r;
  assign pcUpperLatch = pcUpper_r;
  assign pcHighLatch = pcHigh_r;
  assign stackTop = stackTop_r;
  assign qPhase = qPhase_r;
  assign idleCycle = idleCycle_r;
  assign softReset = softReset_r;

  // Call and push leave the return address on top after Q2
  a_push_ret_addr:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ2 && (op_r == crs_pkg::OP_CALL || op_r == crs_pkg::OP_PUSH)
     && stk.depth != crs_pkg::STK_FULL)
    |=> (stk.top == $past(retAddr)) && (stk.depth == $past(stk.depth) + 5'h01))
    else $error("push did not leave return address on top");

  // Call target is visible three edges after the push
  a_call_target:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ2 && op_r == crs_pkg::OP_CALL)
    |=> ##2 pcLoad_r && pc_r == $past(callTarget, 2))
    else $error("relative call target wrong");

  // Call and returns are followed by four idle quarters
  a_idle_second:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ4 && twoCycle) |=> idleCycle_r [*4] ##1 !idleCycle_r)
    else $error("second cycle not idle for four quarters");

  // Reset instruction clears state two edges after Q2
  a_soft_reset:
  assert property (@(posedge sys_clk) disable iff (rst)
    (!effRst && isQ2 && op_r == crs_pkg::OP_RESET)
    |=> softReset_r ##1 (working_r == crs_pkg::W_RST
      && pc_r == crs_pkg::PC_RST && stk.depth == 5'h00 && !highIe_r))
    else $error("reset instruction did not clear state");

  // Interrupt return pops into the PC
  a_intret_pop:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ4 && op_r == crs_pkg::OP_INTRET && stk.depth != 5'h00)
    |=> pc_r == $past(stk.top) && stk.depth == $past(stk.depth) - 5'h01)
    else $error("interrupt return did not pop into PC");

  // The selected enable is set by the interrupt return
  a_intret_enable:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ4 && op_r == crs_pkg::OP_INTRET)
    |=> ($past(lowPrioReturn) ? lowIe_r : highIe_r))
    else $error("interrupt enable not set on return");

  // Shadows restored with s set, untouched otherwise
  a_shadow_copy:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ4 && op_r == crs_pkg::OP_INTRET)
    |=> (opcode_r[0] ? (working_r == $past(workingShadow)
      && status_r == $past(statusShadow)
      && bankSel_r == $past(bankSelectShadow))
      : ($stable(working_r) && $stable(status_r) && $stable(bankSel_r))))
    else $error("shadow restore wrong");

  // Returns never disturb the PC latches
  a_latch_hold:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ4 && !latchWe && (op_r == crs_pkg::OP_INTRET
      || op_r == crs_pkg::OP_LITRET))
    |=> $stable(pcUpper_r) && $stable(pcHigh_r))
    else $error("return changed PC latches");

  // Literal return writes W and PC together
  a_litret_write:
  assert property (@(posedge sys_clk) disable iff (effRst)
    (isQ4 && op_r == crs_pkg::OP_LITRET)
    |=> working_r == $past(opcode_r[7:0]) && pc_r == $past(stk.top)
      && pcLoad_r)
    else $error("literal return wrong");
endmodule // crs_exec_core

/* hw/crs_return_stack.sv */
`timescale 1ns/1ps
module crs_return_stack (
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  crs_stack_if.store stk // Push/pop port
);
  logic [crs_pkg::PC_W-1:0] entry_r [crs_pkg::STK_DEPTH];
  logic [crs_pkg::PTR_W-1:0] depth_r;
  logic full;

  assign full = (depth_r == crs_pkg::STK_FULL);

  // Depth pointer; pushes on a full stack are dropped, pops on an empty one ignored
  always_ff @(posedge sys_clk) begin
    if (rst || stk.clear) begin
      depth_r <= '0;
    end else if (stk.push && !full) begin
      depth_r <= depth_r + 5'h01;
    end else if (stk.pop && depth_r != 5'h00) begin
      depth_r <= depth_r - 5'h01;
    end
  end

  // Entry storage, no reset needed since depth guards reads
  always_ff @(posedge sys_clk) begin
    if (stk.push && !full) begin
      entry_r[depth_r] <= stk.pushData;
    end
  end

  // Empty stack reads as zero
  assign stk.depth = depth_r;
  assign stk.top = (depth_r == 5'h00) ? crs_pkg::PC_RST
                                       : entry_r[depth_r - 5'h01];
endmodule // crs_return_stack

/* include/crs_pkg.sv */
package crs_pkg;
  // Program counter width, stack depth and pointer width
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int PTR_W = 5;
  localparam logic [4:0] STK_FULL = 5'h1f;
  // Opcode patterns
  localparam logic [4:0] CALL_PFX = 5'h1b;
  localparam logic [15:0] RESET_OPC = 16'h00ff;
  localparam logic [14:0] INTRET_PFX = 15'h0008;
  localparam logic [7:0] LITRET_PFX = 8'h0c;
  localparam logic [15:0] PUSH_OPC = 16'h0005;
  localparam int OFS_MSB = 10;
  localparam logic [PC_W-1:0] RET_OFFSET = 21'h000002;
  // Quarter phases of one instruction cycle, one sys_clk each
  localparam logic [1:0] Q_1 = 2'h0;
  localparam logic [1:0] Q_2 = 2'h1;
  localparam logic [1:0] Q_4 = 2'h3;
  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [4:0] PCU_RST = 5'h00;
  localparam logic [7:0] PCH_RST = 8'h00;
  // Register port map
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STATE = 2'h1;
  localparam logic [1:0] ADDR_PC = 2'h2;
  localparam logic [1:0] ADDR_TOP = 2'h3;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_IDLE_BIT = 8;
  localparam int ST_HIE_BIT = 9;
  localparam int ST_LIE_BIT = 10;
  // Decoded operation
  typedef enum logic [2:0] {
    OP_NONE, OP_CALL, OP_RESET, OP_INTRET, OP_LITRET, OP_PUSH, OP_OTHER
  } crs_op_type;
endpackage

/* include/crs_stack_if.sv */
`timescale 1ns/1ps
interface crs_stack_if;
  logic push;
  logic pop;
  logic clear;
  logic [crs_pkg::PC_W-1:0] pushData;
  logic [crs_pkg::PC_W-1:0] top;
  logic [crs_pkg::PTR_W-1:0] depth;
  modport ctrl (output push, pop, clear, pushData, input top, depth);
  modport store (input push, pop, clear, pushData, output top, depth);
endinterface

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic masterClearPin_n = 1'b1;
  logic [15:0] opcode = 16'h0000;
  logic [20:0] instrAddr = 21'h000000;
  logic opValid = 1'b0;
  logic lowPrioReturn = 1'b0;
  logic intEnableClr = 1'b0;
  logic [7:0] workingShadow = 8'h00;
  logic [7:0] statusShadow = 8'h00;
  logic [3:0] bankSelectShadow = 4'h0;
  logic latchWe = 1'b0;
  logic [12:0] latchData = 13'h0000;
  logic [1:0] regAddr = 2'h0;
  logic [31:0] regWrData = 32'h00000000;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData;
  logic [20:0] pcOut;
  logic pcLoad;
  logic [7:0] workingReg;
  logic [7:0] statusReg;
  logic [3:0] bankSelectReg;
  logic highPrioIntEnable;
  logic lowPrioIntEnable;
  logic [4:0] pcUpperLatch;
  logic [7:0] pcHighLatch;
  logic [20:0] stackTop;
  logic [1:0] qPhase;
  logic idleCycle;
  logic softReset;
  int n_mismatch = 0;
  int n_tests = 0;
  int idleCnt = 0;
  int softCnt = 0;
  logic rdPend = 1'b0;
  logic [31:0] seed = 32'h1f153485;
  logic [30:0] loadQ[$];
  logic [31:0] rdQ[$];
  wire [30:0] loadSeen = {pcOut, workingReg, highPrioIntEnable,
                          lowPrioIntEnable};

  crs_exec_core u_dut (
    .sys_clk(sys_clk), .rst(rst), .masterClearPin_n(masterClearPin_n),
    .opcode(opcode), .instrAddr(instrAddr), .opValid(opValid),
    .lowPrioReturn(lowPrioReturn), .intEnableClr(intEnableClr),
    .workingShadow(workingShadow), .statusShadow(statusShadow),
    .bankSelectShadow(bankSelectShadow), .latchWe(latchWe),
    .latchData(latchData), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .pcOut(pcOut), .pcLoad(pcLoad), .workingReg(workingReg),
    .statusReg(statusReg), .bankSelectReg(bankSelectReg),
    .highPrioIntEnable(highPrioIntEnable),
    .lowPrioIntEnable(lowPrioIntEnable), .pcUpperLatch(pcUpperLatch),
    .pcHighLatch(pcHighLatch), .stackTop(stackTop), .qPhase(qPhase),
    .idleCycle(idleCycle), .softReset(softReset)
  );

  // 10 MHz core clock
  always #50 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Several steps, so neighbouring draws are not mere shifts
  task automatic rnd();
    repeat (8) seed = lfsr(seed);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic regWrite(input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask

  task automatic regRead(input logic [1:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Present one opcode for the next Q1 edge, then let it finish
  task automatic issue(input logic [15:0] op, input logic [20:0] a);
    int guard;
    guard = 0;
    do begin
      @(posedge sys_clk);
      guard++;
    end while (!(qPhase === crs_pkg::Q_4 && idleCycle === 1'b0)
               && guard < 40);
    if (guard >= 40) n_mismatch++;
    opcode <= op;
    instrAddr <= a;
    opValid <= 1'b1;
    @(posedge sys_clk);
    opValid <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask

  // Watcher: pre-edge values are settled, so no ordering race
  always @(posedge sys_clk) begin
    if (rdPend) chk(regRdData, rdQ.pop_front());
    if (pcLoad === 1'b1) begin
      if (loadQ.size() == 0) chk(32'h1, 32'h0);
      else chk(loadSeen, loadQ.pop_front());
    end
    if (idleCycle === 1'b1) idleCnt++;
    if (softReset === 1'b1) softCnt++;
    rdPend = regRdStb;
  end

  // Watchdog far beyond the expected run length
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    int i;
    logic [20:0] addr;
    logic [20:0] tgt;
    logic [20:0] pushRet;
    logic [10:0] ofs;
    logic [12:0] expLatch;
    logic [7:0] expW;
    logic expHi;
    logic expLo;
    logic sBit;
    expW = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    regRead(crs_pkg::ADDR_CTRL, 32'h00000001);
    regRead(crs_pkg::ADDR_PC, 32'h00000000);
    // Latches set once; no return may disturb them
    rnd();
    expLatch = seed[12:0];
    latchData <= expLatch;
    latchWe <= 1'b1;
    @(posedge sys_clk);
    latchWe <= 1'b0;
    rnd();
    pushRet = {seed[20:1], 1'b0} + 21'h000002;
    issue(crs_pkg::PUSH_OPC, pushRet - 21'h000002);
    chk(stackTop, pushRet);
    // Boundary offsets first, then random ones; each call is undone
    for (i = 0; i < 6; i++) begin
      rnd();
      addr = {seed[20:1], 1'b0};
      ofs = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : seed[31:21];
      tgt = addr + 21'h000002 + {{9{ofs[10]}}, ofs, 1'b0};
      loadQ.push_back({tgt, expW, 1'b0, 1'b0});
      intEnableClr <= 1'b1;
      idleCnt = 0;
      issue({crs_pkg::CALL_PFX, ofs}, addr);
      intEnableClr <= 1'b0;
      chk(stackTop, addr + 21'h000002);
      chk(idleCnt, 32'd4);
      lowPrioReturn <= i[0];
      workingShadow <= seed[7:0];
      statusShadow <= seed[15:8];
      bankSelectShadow <= seed[19:16];
      sBit = (i % 3 == 2);
      expHi = 1'b0;
      expLo = 1'b0;
      idleCnt = 0;
      if (i % 3 == 0) begin
        expW = seed[27:20];
        loadQ.push_back({addr + 21'h000002, expW, 2'b00});
        issue({crs_pkg::LITRET_PFX, expW}, tgt);
      end else begin
        if (sBit) expW = seed[7:0];
        expHi = !i[0];
        expLo = i[0];
        loadQ.push_back({addr + 21'h000002, expW, expHi, expLo});
        issue({crs_pkg::INTRET_PFX, sBit}, tgt);
        if (sBit) chk({statusReg, bankSelectReg},
                      {seed[15:8], seed[19:16]});
      end
      chk(idleCnt, 32'd4);
      chk(stackTop, pushRet);
      chk({pcUpperLatch, pcHighLatch}, expLatch);
    end
    // Execution disabled: a call must leave PC alone
    regWrite(crs_pkg::ADDR_CTRL, 32'h00000000);
    issue({crs_pkg::CALL_PFX, 11'h005}, 21'h000100);
    chk(pcOut, addr + 21'h000002);
    regWrite(crs_pkg::ADDR_CTRL, 32'h00000001);
    regRead(crs_pkg::ADDR_STATE, {21'h0, expLo, expHi, 9'h001});
    softCnt = 0;
    issue(crs_pkg::RESET_OPC, 21'h000200);
    chk(softCnt, 32'd1);
    chk(loadSeen, 31'h0);
    chk({pcUpperLatch, pcHighLatch}, 32'h0);
    chk(stackTop, 32'h0);
    regRead(crs_pkg::ADDR_CTRL, 32'h00000001);
    regRead(crs_pkg::ADDR_STATE, 32'h00000000);
    // The external pin must clear the same state
    issue(crs_pkg::PUSH_OPC, 21'h000300);
    masterClearPin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    masterClearPin_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(pcOut, 32'h0);
    chk(stackTop, 32'h0);
    conclude();
  end
endmodule // tb
